/* File: bdcc_regs.svh */
// register offsets, field positions, reset values and timing of the backup clock control
`ifndef BDCC_REGS_SVH
`define BDCC_REGS_SVH

`define BDCC_OFS_CTRL 8'h20
`define BDCC_OFS_STAT 8'h40
`define BDCC_OFS_IEN 8'h44
`define BDCC_OFS_ICLR 8'h48

`define BDCC_BIT_OSC_EN 0
`define BDCC_BIT_OSC_RDY 1
`define BDCC_BIT_BYPASS 2
`define BDCC_BIT_SEL_LO 8
`define BDCC_BIT_SEL_HI 9
`define BDCC_BIT_RTC_GATE 15
`define BDCC_BIT_SOFT_RST 16

`define BDCC_RST_CTRL 32'h0000_0000
`define BDCC_RST_IRQ 4'h0

`define BDCC_NUM_EVENTS 4
`define BDCC_EV_RDY_RISE 0
`define BDCC_EV_RDY_FALL 1
`define BDCC_EV_WR_BLOCK 2
`define BDCC_EV_SEL_LOCK 3

`define BDCC_WAIT_MAX 3

`endif

/* File: bdcc_pkg.sv */
// types shared by the backup clock control files
`default_nettype none

package bdcc_pkg;

  // order gives the codes 0..3 of the source field
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_SLOW_EXT,
    SRC_SLOW_INT,
    SRC_FAST_EXT_DIV128
  } bdcc_rtc_src_t;

  typedef struct packed {
    logic backupDomainSoftReset;
    logic rtcClockGateEnable;
    bdcc_rtc_src_t rtcClockSourceSelect;
    logic slowExtOscBypass;
    logic slowExtOscEnable;
  } bdcc_ctrl_t;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } bdcc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bdcc_apb_rsp_t;

endpackage

`default_nettype wire

/* File: bdcc_wait_gen.sv */
// wait-state generator for the register bus
`include "bdcc_regs.svh"
`default_nettype none

module bdcc_wait_gen #(
  parameter int unsigned BACK_TO_BACK_WAIT = `BDCC_WAIT_MAX
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic setupPhase,
  input wire logic accessPhase,
  input wire logic readyQ,
  output logic readyNext
);

  initial
  begin
    if (BACK_TO_BACK_WAIT > `BDCC_WAIT_MAX)
      $error("bdcc_wait_gen: wait count above the supported maximum");
  end

  logic [1:0] waitCnt_q;
  logic [1:0] waitCnt_d;
  logic lastDone_q;
  logic backToBack;
  logic [1:0] waitLoad;

  // ---------------------------------------------------------------
  // wait count
  // ---------------------------------------------------------------
  assign backToBack = setupPhase && lastDone_q;
  assign waitLoad = backToBack ? 2'(BACK_TO_BACK_WAIT) : 2'h0;
  assign waitCnt_d = setupPhase ? waitLoad :
                     (accessPhase && waitCnt_q != 2'h0) ? waitCnt_q - 2'h1 : waitCnt_q;
  // ready is registered, so it is chosen one cycle early
  assign readyNext = setupPhase ? (waitLoad == 2'h0) :
                     (accessPhase && !readyQ && waitCnt_q == 2'h1);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      waitCnt_q <= 2'h0;
      lastDone_q <= 1'b0;
    end
    else if (ce)
    begin
      waitCnt_q <= waitCnt_d;
      lastDone_q <= accessPhase && readyQ;
    end
  end

endmodule

`default_nettype wire

/* File: bdcc_top.sv */
// backup-domain clock control: control register, apb slave and event interrupt
//
// Overview of operation
// [R1] control register cleared only by backup reset
// [R2] word/half/byte access, zero to three waits
// [R3] protected fields change only with write enable
// [R4] bit 0 switches slow external oscillator
// [R5] bit 1 shows slow external clock ready
// [R6] bit 2 selects external clock bypass
// [R7] bits 9:8 route the rtc clock source
// [R8] rtc source changes only after domain reset
// [R9] bit 15 gates the rtc clock
// [R10] bit 16 holds backup domain in reset
// [R11] reserved bits read zero, ignore writes
`include "bdcc_regs.svh"
`default_nettype none

module bdcc_top #(
  parameter int unsigned BACK_TO_BACK_WAIT = `BDCC_WAIT_MAX,
  parameter int unsigned NUM_EVENTS = `BDCC_NUM_EVENTS
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic backupPowerReset,
  input wire logic backupWriteEnable,
  input wire logic slowExtOscReadyRaw,
  input wire bdcc_pkg::bdcc_apb_req_t apbReq,
  output bdcc_pkg::bdcc_apb_rsp_t apbRsp,
  output logic slowExtOscEnable,
  output logic slowExtOscBypass,
  output bdcc_pkg::bdcc_rtc_src_t rtcClockSourceSelect,
  output logic rtcClockGate,
  output logic backupDomainReset,
  output logic irq
);

  initial
  begin
    if (NUM_EVENTS != `BDCC_NUM_EVENTS)
      $error("bdcc_top: event count must match the status layout");
    if (BACK_TO_BACK_WAIT > `BDCC_WAIT_MAX)
      $error("bdcc_top: wait count above the supported maximum");
  end

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] ofs);
    addrHit = (addr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [31:0] laneMask(input logic [3:0] strb);
    laneMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // bits that exist in the control word; everything else reads zero
  function automatic logic [31:0] definedBits();
    definedBits = 32'h0;
    definedBits[`BDCC_BIT_OSC_EN] = 1'b1;
    definedBits[`BDCC_BIT_OSC_RDY] = 1'b1;
    definedBits[`BDCC_BIT_BYPASS] = 1'b1;
    definedBits[`BDCC_BIT_SEL_LO] = 1'b1;
    definedBits[`BDCC_BIT_SEL_HI] = 1'b1;
    definedBits[`BDCC_BIT_RTC_GATE] = 1'b1;
    definedBits[`BDCC_BIT_SOFT_RST] = 1'b1;
  endfunction

  // ---------------------------------------------------------------
  // ready input synchroniser
  // ---------------------------------------------------------------
  logic rdySync1_q;
  logic rdySync2_q;
  logic rdyPrev_q;
  logic [2:0] rdyFill_q;
  logic rdyEdgeValid;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rdySync1_q <= 1'b0;
      rdySync2_q <= 1'b0;
      rdyPrev_q <= 1'b0;
      rdyFill_q <= 3'h0;
    end
    else if (ce)
    begin
      rdySync1_q <= slowExtOscReadyRaw;
      rdySync2_q <= rdySync1_q;
      rdyPrev_q <= rdySync2_q;
      rdyFill_q <= {rdyFill_q[1:0], 1'b1};
    end
  end

  // stages restart empty after srst: a steady ready pin must not look like an edge
  assign rdyEdgeValid = rdyFill_q[2];

  // ---------------------------------------------------------------
  // bus phases
  // ---------------------------------------------------------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic setupPhase;
  logic accessPhase;
  logic commit;
  logic readyNext;
  logic wrCommit;
  logic hitCtrl;
  logic hitStat;
  logic hitIen;
  logic hitIclr;
  logic hitAny;
  logic [31:0] wrMask;

  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessPhase = apbReq.psel && apbReq.penable;
  assign commit = accessPhase && pready_q;
  assign wrCommit = commit && apbReq.pwrite;
  assign hitCtrl = addrHit(apbReq.paddr, `BDCC_OFS_CTRL);
  assign hitStat = addrHit(apbReq.paddr, `BDCC_OFS_STAT);
  assign hitIen = addrHit(apbReq.paddr, `BDCC_OFS_IEN);
  assign hitIclr = addrHit(apbReq.paddr, `BDCC_OFS_ICLR);
  assign hitAny = hitCtrl || hitStat || hitIen || hitIclr;
  // byte and half-word writes touch only their lanes of ctrl and ien; the clear register takes pwdata whatever the strobes
  assign wrMask = laneMask(apbReq.pstrb); // R2

  bdcc_wait_gen #(
    .BACK_TO_BACK_WAIT(BACK_TO_BACK_WAIT)
  ) u_wait (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .setupPhase(setupPhase),
    .accessPhase(accessPhase),
    .readyQ(pready_q),
    .readyNext(readyNext) // R2
  );

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  bdcc_pkg::bdcc_ctrl_t ctrl_q;
  bdcc_pkg::bdcc_ctrl_t ctrl_d;
  logic domainReset;
  logic ctrlWrite;
  logic [31:0] newWord;
  logic [31:0] oldWord;
  logic protectedTouched;
  logic selWriteTried;
  logic selAllowed;
  bdcc_pkg::bdcc_rtc_src_t selWritten;
  localparam logic [31:0] CTRL_RESET = `BDCC_RST_CTRL;

  assign domainReset = backupPowerReset || ctrl_q.backupDomainSoftReset; // R10
  assign ctrlWrite = wrCommit && hitCtrl;
  assign oldWord = {15'h0, ctrl_q.backupDomainSoftReset, ctrl_q.rtcClockGateEnable,
                    5'h0, ctrl_q.rtcClockSourceSelect, 5'h0, ctrl_q.slowExtOscBypass,
                    1'b0, ctrl_q.slowExtOscEnable};
  assign newWord = (apbReq.pwdata & wrMask) | (oldWord & ~wrMask);
  assign protectedTouched = ctrlWrite && (apbReq.pstrb[0] || apbReq.pstrb[1]);
  assign selWritten = bdcc_pkg::bdcc_rtc_src_t'(newWord[`BDCC_BIT_SEL_HI:`BDCC_BIT_SEL_LO]);
  assign selWriteTried = ctrlWrite && backupWriteEnable && apbReq.pstrb[1]
                         && selWritten != ctrl_q.rtcClockSourceSelect;
  // once chosen the source is locked until the domain is reset
  assign selAllowed = ctrl_q.rtcClockSourceSelect == bdcc_pkg::SRC_NONE; // R8

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (ctrlWrite)
    begin
      // soft reset bit is not behind the write enable
      ctrl_d.backupDomainSoftReset = newWord[`BDCC_BIT_SOFT_RST]; // R10
      if (backupWriteEnable) // R3
      begin
        ctrl_d.slowExtOscEnable = newWord[`BDCC_BIT_OSC_EN]; // R4
        ctrl_d.slowExtOscBypass = newWord[`BDCC_BIT_BYPASS]; // R6
        ctrl_d.rtcClockGateEnable = newWord[`BDCC_BIT_RTC_GATE]; // R9
        if (selAllowed) // R8
          ctrl_d.rtcClockSourceSelect = selWritten; // R7
      end
    end
    // while the domain is in reset everything but the reset bit stays clear
    if (ctrl_q.backupDomainSoftReset)
    begin
      ctrl_d.slowExtOscEnable = 1'b0; // R10
      ctrl_d.slowExtOscBypass = 1'b0;
      ctrl_d.rtcClockGateEnable = 1'b0;
      ctrl_d.rtcClockSourceSelect = bdcc_pkg::SRC_NONE;
    end
  end

  // system reset deliberately absent: only the backup domain clears this
  always_ff @(posedge clk_sys)
  begin
    if (backupPowerReset)
    begin
      ctrl_q.slowExtOscEnable <= CTRL_RESET[`BDCC_BIT_OSC_EN]; // R1
      ctrl_q.slowExtOscBypass <= CTRL_RESET[`BDCC_BIT_BYPASS];
      ctrl_q.rtcClockSourceSelect <=
        bdcc_pkg::bdcc_rtc_src_t'(CTRL_RESET[`BDCC_BIT_SEL_HI:`BDCC_BIT_SEL_LO]);
      ctrl_q.rtcClockGateEnable <= CTRL_RESET[`BDCC_BIT_RTC_GATE];
      ctrl_q.backupDomainSoftReset <= CTRL_RESET[`BDCC_BIT_SOFT_RST];
    end
    else if (ce)
      ctrl_q <= ctrl_d;
  end

  // ---------------------------------------------------------------
  // clock control outputs
  // ---------------------------------------------------------------
  logic rtcGateNext;

  // a gate with no source would pass nothing, so keep it closed
  assign rtcGateNext = ctrl_d.rtcClockGateEnable
                       && ctrl_d.rtcClockSourceSelect != bdcc_pkg::SRC_NONE; // R9

  always_ff @(posedge clk_sys)
  begin
    if (backupPowerReset)
    begin
      slowExtOscEnable <= 1'b0;
      slowExtOscBypass <= 1'b0;
      rtcClockSourceSelect <= bdcc_pkg::SRC_NONE;
      rtcClockGate <= 1'b0;
      backupDomainReset <= 1'b1;
    end
    else if (ce)
    begin
      slowExtOscEnable <= ctrl_d.slowExtOscEnable; // R4
      slowExtOscBypass <= ctrl_d.slowExtOscBypass; // R6
      rtcClockSourceSelect <= ctrl_d.rtcClockSourceSelect; // R7
      rtcClockGate <= rtcGateNext;
      backupDomainReset <= ctrl_d.backupDomainSoftReset || domainReset; // R10
    end
  end

  // ---------------------------------------------------------------
  // events and interrupt
  // ---------------------------------------------------------------
  logic [NUM_EVENTS-1:0] evPulse;
  logic [NUM_EVENTS-1:0] stat_q;
  logic [NUM_EVENTS-1:0] ien_q;
  logic [NUM_EVENTS-1:0] clrReq;
  logic [NUM_EVENTS-1:0] ienWord;

  assign evPulse[`BDCC_EV_RDY_RISE] = rdyEdgeValid && rdySync2_q && !rdyPrev_q; // R5
  assign evPulse[`BDCC_EV_RDY_FALL] = rdyEdgeValid && !rdySync2_q && rdyPrev_q; // R5
  assign evPulse[`BDCC_EV_WR_BLOCK] = protectedTouched && !backupWriteEnable; // R3
  assign evPulse[`BDCC_EV_SEL_LOCK] = selWriteTried && !selAllowed; // R8
  assign clrReq = (wrCommit && hitIclr) ? apbReq.pwdata[NUM_EVENTS-1:0] : '0;
  assign ienWord = (apbReq.pwdata[NUM_EVENTS-1:0] & wrMask[NUM_EVENTS-1:0])
                   | (ien_q & ~wrMask[NUM_EVENTS-1:0]);

  // an event in the clearing cycle survives the clear
  for (genvar i = 0; i < NUM_EVENTS; i++)
  begin : g_stat
    always_ff @(posedge clk_sys)
    begin
      if (srst)
        stat_q[i] <= 1'b0;
      else if (ce)
        stat_q[i] <= evPulse[i] || (stat_q[i] && !clrReq[i]);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ien_q <= `BDCC_RST_IRQ;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      if (wrCommit && hitIen)
        ien_q <= ienWord;
      irq <= |(stat_q & ien_q);
    end
  end

  // ---------------------------------------------------------------
  // read data and bus answer
  // ---------------------------------------------------------------
  logic [31:0] rdWord;
  logic [31:0] ctrlRead;

  // unused field bits are built as constant zero
  assign ctrlRead = (oldWord | {30'h0, rdySync2_q, 1'b0}) & definedBits(); // R5 R11
  assign rdWord = hitCtrl ? ctrlRead :
                  hitStat ? {{(32-NUM_EVENTS){1'b0}}, stat_q} :
                  hitIen ? {{(32-NUM_EVENTS){1'b0}}, ien_q} :
                  32'h0;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else if (ce)
    begin
      pready_q <= readyNext; // R2
      if (readyNext)
      begin
        pslverr_q <= !hitAny;
        prdata_q <= apbReq.pwrite ? 32'h0 : rdWord;
      end
      else if (commit)
      begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0;
      end
    end
  end

  assign apbRsp.prdata = prdata_q;
  assign apbRsp.pready = pready_q;
  assign apbRsp.pslverr = pslverr_q;

endmodule

`default_nettype wire

/* File: bdcc_asserts.sv */
// port checker for the backup clock control
`default_nettype none
module bdcc_asserts #(
  parameter int unsigned BACK_TO_BACK_WAIT = 3,
  parameter int unsigned NUM_EVENTS = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic backupPowerReset,
  input wire logic backupWriteEnable,
  input wire logic slowExtOscReadyRaw,
  input wire bdcc_pkg::bdcc_apb_req_t apbReq,
  input wire bdcc_pkg::bdcc_apb_rsp_t apbRsp,
  input wire logic slowExtOscEnable,
  input wire logic slowExtOscBypass,
  input wire bdcc_pkg::bdcc_rtc_src_t rtcClockSourceSelect,
  input wire logic rtcClockGate,
  input wire logic backupDomainReset,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // helpers
  // ----
  wire logic done = apbReq.psel & apbReq.penable & apbRsp.pready;
  wire logic ctrlHit = done & (apbReq.paddr == 8'h20);
  // soft reset bit is unguarded, so writes with data bit 16 set are left out
  wire logic lockedWr = ctrlHit & apbReq.pwrite & !backupWriteEnable & !apbReq.pwdata[16]
    & !backupDomainReset & !backupPowerReset;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // ----
  // properties
  // ----
  a_gate_has_src: assert property (rtcClockGate |-> rtcClockSourceSelect != 2'h0)
    else $error("rtc gate open without a source");
  a_power_clears: assert property (backupPowerReset |=> backupDomainReset
    && !rtcClockGate && !slowExtOscEnable && rtcClockSourceSelect == 2'h0)
    else $error("power reset left control outputs set");
  a_soft_holds: assert property (backupDomainReset [*2] |-> !slowExtOscEnable
    && !slowExtOscBypass && !rtcClockGate)
    else $error("fields active during domain reset");
  a_src_locked: assert property (rtcClockSourceSelect != 2'h0 |=>
    rtcClockSourceSelect == $past(rtcClockSourceSelect) || rtcClockSourceSelect == 2'h0)
    else $error("rtc source changed without reset");
  a_one_ready: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("pready held two cycles");
  a_idle_fast: assert property (apbReq.psel && !apbReq.penable
    && !$past(apbRsp.pready) && ce |=> apbRsp.pready)
    else $error("isolated access got wait states");
  a_wait_bound: assert property (apbReq.psel && !apbReq.penable |-> ##[1:4] apbRsp.pready)
    else $error("more than three wait states");
  a_guard_keeps: assert property (lockedWr |=> ($stable(slowExtOscEnable)
    && $stable(slowExtOscBypass) && $stable(rtcClockGate)
    && $stable(rtcClockSourceSelect)) [*2])
    else $error("guarded field changed without write enable");
  a_resv_zero: assert property (ctrlHit && !apbReq.pwrite |->
    (apbRsp.prdata & 32'hfffe_7cf8) == 32'h0)
    else $error("reserved control bits read nonzero");
  c_locked: cover property (lockedWr);
  c_bus_err: cover property (done && apbRsp.pslverr);
  c_irq: cover property (irq ##1 !irq);
endmodule

bind bdcc_top bdcc_asserts #(
  .BACK_TO_BACK_WAIT(BACK_TO_BACK_WAIT), .NUM_EVENTS(NUM_EVENTS)
) bdcc_asserts_inst (
  .clk_sys(clk_sys), .srst(srst), .ce(ce), .backupPowerReset(backupPowerReset),
  .backupWriteEnable(backupWriteEnable), .slowExtOscReadyRaw(slowExtOscReadyRaw),
  .apbReq(apbReq), .apbRsp(apbRsp), .slowExtOscEnable(slowExtOscEnable),
  .slowExtOscBypass(slowExtOscBypass), .rtcClockSourceSelect(rtcClockSourceSelect),
  .rtcClockGate(rtcClockGate), .backupDomainReset(backupDomainReset), .irq(irq)
);
`default_nettype wire

/* File: bdcc_osc_model.sv */
// slow external oscillator model for the backup clock control bench
`default_nettype none
module bdcc_osc_model #(
  parameter int SETTLE = 32
) (
  input wire logic clk_sys,
  input wire logic enable,
  input wire logic bypass,
  output var logic readyRaw
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial readyRaw = 1'b0;
  // a supplied clock is usable sooner than a crystal settles
  always @(posedge clk_sys)
  begin
    cnt <= enable ? cnt + 1 : 0;
    readyRaw <= enable && cnt >= (bypass ? SETTLE / 2 : SETTLE);
  end
endmodule
`default_nettype wire

/* File: bdcc_top_tb.sv */
// self-checking bench for the backup clock control
`default_nettype none
module bdcc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic pwrRst = 1'b1;
  logic wrEn = 1'b1;
  logic rdyRaw;
  logic oscEn;
  logic bypass;
  logic gate;
  logic backup_domain_soft_reset;
  logic irq;
  logic err;
  logic [31:0] rd;
  bdcc_pkg::bdcc_rtc_src_t src;
  bdcc_pkg::bdcc_apb_req_t req = '0;
  bdcc_pkg::bdcc_apb_rsp_t rsp;
  wire logic [5:0] outs = {backup_domain_soft_reset, gate, src, bypass, oscEn};
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  always #25 clk_sys = ~clk_sys;
  bdcc_top bdcc_top_inst (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .backupPowerReset(pwrRst),
    .backupWriteEnable(wrEn), .slowExtOscReadyRaw(rdyRaw), .apbReq(req), .apbRsp(rsp),
    .slowExtOscEnable(oscEn), .slowExtOscBypass(bypass), .rtcClockSourceSelect(src),
    .rtcClockGate(gate), .backupDomainReset(backup_domain_soft_reset), .irq(irq)
  );
  bdcc_osc_model bdcc_osc_model_inst (
    .clk_sys(clk_sys), .enable(oscEn), .bypass(bypass), .readyRaw(rdyRaw)
  );
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // leaves the bus held so a following call makes a back-to-back transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    req.pstrb <= s;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
  endtask
  task automatic idle(input int n);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hf);
    idle(2);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(what, e, rd);
    idle(1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch++;
      test_done;
    end
  end
  // ----
  // sequence
  // ----
  initial
  begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    pwrRst <= 1'b0;
    rdchk("ctrl", 8'h20, 32'h0);
    xfer(1'b1, 8'h20, 32'hfffe_ffff, 4'hf);
    rdchk("ctrl", 8'h20, 32'h0000_8305);
    chk("outs", 32'h1f, {26'h0, outs});
    idle(40);
    rdchk("ctrl", 8'h20, 32'h0000_8307);
    wr(8'h44, 32'h0);
    wrEn <= 1'b0;
    wr(8'h20, 32'h0);
    chk("outs", 32'h1f, {26'h0, outs});
    chk("irq", 32'h0, {31'h0, irq});
    rdchk("stat", 8'h40, 32'h5);
    wr(8'h44, 32'h4);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h48, 32'h5);
    chk("irq", 32'h0, {31'h0, irq});
    rdchk("stat", 8'h40, 32'h0);
    rdchk("clr", 8'h48, 32'h0);
    wrEn <= 1'b1;
    wr(8'h20, 32'h0000_8205);
    chk("outs", 32'h1f, {26'h0, outs});
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h20, 32'h0001_0000);
      chk("outs", 32'h20, {26'h0, outs});
      wr(8'h20, 32'h0);
      wr(8'h20, {16'h0, 1'b1, 5'h0, c[1:0], 8'h0});
      chk("outs", {27'h0, c != 0, c[1:0], 2'h0}, {26'h0, outs});
    end
    xfer(1'b1, 8'h20, 32'hffff_ff05, 4'h1);
    idle(40);
    rdchk("ctrl", 8'h20, 32'h0000_8307);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    idle(4);
    rdchk("ctrl", 8'h20, 32'h0000_8307);
    rdchk("stat", 8'h40, 32'h0);
    pwrRst <= 1'b1;
    idle(2);
    pwrRst <= 1'b0;
    idle(40);
    rdchk("ctrl", 8'h20, 32'h0);
    xfer(1'b0, 8'h30, 32'h0, 4'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("rdata", 32'h0, rd);
    idle(1);
    // ready rises while the clock enable is low: nothing may move until it returns
    wr(8'h44, 32'h1);
    wr(8'h20, 32'h1);
    ce <= 1'b0;
    idle(50);
    chk("irq", 32'h0, {31'h0, irq});
    chk("outs", 32'h1, {26'h0, outs});
    ce <= 1'b1;
    idle(6);
    chk("irq", 32'h1, {31'h0, irq});
    test_done;
  end
endmodule
`default_nettype wire
